// [sim/gw_diag_chk.sv]
// port checks for the gateway config and diagnostic block
// assumes bind onto the block, one clock, async high reset
`timescale 1ns/10ps
module gw_diag_chk (
	input  wire logic             i_sys_clk,
	input  wire logic             i_reset,
	input  wire logic             i_rd,
	input  wire logic             i_wr,
	input  wire logic             i_lost_input,
	input  wire logic [31:0]      o_rdata,
	input  gw_cfg_pkg::out_frame_s i_out_frame,
	input  gw_cfg_pkg::event_s    i_module_err,
	input  gw_cfg_pkg::event_s    i_nv_fault,
	input  gw_cfg_pkg::cfg_s      o_cfg,
	input  wire logic             o_in_refresh,
	input  wire logic             o_out_refresh,
	input  gw_cfg_pkg::diag_view_s o_diag_view
);
	import gw_cfg_pkg::*;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// ****
	// properties
	// ****
	// higher sources would mask the one under test
	wire quiet = !i_out_frame.valid && !i_nv_fault.valid && !i_wr;
	wire [7:0] cnt = o_diag_view.b0;
	property p_view;
		o_diag_view.b1 == ((cnt != 0) ? 8'h05 : 8'h00) &&
		o_diag_view.b2 == ((cnt != 0) ? 8'ha0 : 8'h00) &&
		o_diag_view.b4 == 8'h00;
	endproperty
	a_view: assert property (p_view) else $error("view bytes wrong");
	property p_max; cnt <= 8'h0a; endproperty
	a_max: assert property (p_max) else $error("count over ten");
	property p_full;
		cnt == 8'h0a && !(i_out_frame.valid && i_out_frame.ctrl[0])
		|=> cnt == 8'h0a;
	endproperty
	a_full: assert property (p_full) else $error("full store moved");
	property p_lost;
		i_lost_input && quiet && cnt < 8'h0a
		|=> o_diag_view.b3 == 8'h3c && o_diag_view.b5 == 8'h00;
	endproperty
	a_lost: assert property (p_lost) else $error("lost input code");
	property p_inref; i_out_frame.valid |=> o_in_refresh; endproperty
	a_inref: assert property (p_inref) else $error("no in refresh");
	property p_auto;
		i_out_frame.valid && o_cfg.auto_out |=> o_out_refresh;
	endproperty
	a_auto: assert property (p_auto) else $error("no out refresh");
	property p_stop; o_cfg.data8 |-> !o_cfg.stop2; endproperty
	a_stop: assert property (p_stop) else $error("stop2 with 8 bits");
	property p_rd; o_rdata != 32'h0 |-> $past(i_rd); endproperty
	a_rd: assert property (p_rd) else $error("stray read data");
	property p_slave;
		!o_cfg.master && i_module_err.valid && !i_lost_input && quiet
		|=> $stable(cnt);
	endproperty
	a_slave: assert property (p_slave) else $error("slave module err");
endmodule // gw_diag_chk
bind fieldbus_gateway_config_diag gw_diag_chk i_gw_diag_chk (.*);

// [sim/pb_master_model.sv]
// profibus master stand-in sending cyclic output frames
// assumes frames are one-cycle pulses launched after a rising edge
`timescale 1ns/10ps
module pb_master_model (
	input  wire logic              i_sys_clk,
	output gw_cfg_pkg::out_frame_s o_frame
);
	import gw_cfg_pkg::*;
	logic [7:0] cmd;
	initial begin
		cmd = 8'h00;
		o_frame = '0;
	end
	// a step other than zero or one models a lost frame on purpose
	task automatic send(input logic [7:0] ctrl, input logic [7:0] step);
		@(posedge i_sys_clk);
		cmd = cmd + step;
		o_frame <= '{1'b1, cmd, ctrl, 8'h00};
		@(posedge i_sys_clk);
		o_frame.valid <= 1'b0;
	endtask
endmodule // pb_master_model

// [sim/tb_fieldbus_gateway_config_diag.sv]
// bench for the gateway config and diagnostic block
// assumes register port with read data one cycle after the strobe
`include "gw_cfg_map.svh"
`timescale 1ns/10ps
module tb_fieldbus_gateway_config_diag;
	import gw_cfg_pkg::*;
	logic       i_sys_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic       i_pb_exchange = 1'b1, i_lost_input = 1'b0;
	logic       i_mb_link_ok = 1'b1;
	safe_s      o_safe;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	out_frame_s i_out_frame;
	event_s     i_module_err = '0, i_nv_fault = '0;
	diag_view_s o_diag_view;
	int         mismatches = 0, tests_run = 0;
	always #12.5 i_sys_clk = ~i_sys_clk;
	fieldbus_gateway_config_diag #(.MS_CYCLES(4))
		i_fieldbus_gateway_config_diag (.i_sys_clk, .i_reset, .i_addr,
		.i_wdata, .i_wr, .i_rd, .o_rdata, .i_pb_exchange,
		.i_mb_link_ok, .i_out_frame, .i_module_err, .i_nv_fault,
		.i_lost_input, .i_query_sent(1'b0), .i_reply_seen(1'b0),
		.i_fmt_module(5'h00), .i_fmt_data(32'h0), .o_cfg(), .o_baud_tick(),
		.o_poll_tick(), .o_reply_timeout(), .o_safe, .o_out_refresh(),
		.o_out_select(), .o_in_refresh(), .o_setup_mode(), .o_diag_view,
		.o_fmt_data());
	pb_master_model i_pb_master_model (.i_sys_clk, .o_frame(i_out_frame));
	// ****
	// tasks
	// ****
	task automatic chk(input string n, input logic [47:0] s, e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 chk("rdata", {16'h0, o_rdata}, {16'h0, e});
	endtask
	// nv selects the memory fault source, else the module error source
	task automatic fire(input logic nv, input logic [7:0] m, c);
		@(posedge i_sys_clk);
		if (nv) i_nv_fault <= '{1'b1, m, c};
		else i_module_err <= '{1'b1, m, c};
		i_lost_input <= (m == 8'h3c);
		@(posedge i_sys_clk);
		i_nv_fault <= '0;
		i_module_err <= '0;
		i_lost_input <= 1'b0;
		#1;
	endtask
	task automatic end_sim();
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		rd(`GW_OFF_CFG, 32'h22);
		wr(`GW_OFF_CFG, 32'h42);
		rd(`GW_OFF_CFG, 32'h42);
		wr(`GW_OFF_SLAVE, 32'h0);
		wr(`GW_OFF_SLAVE, 32'hf8);
		rd(`GW_OFF_SLAVE, 32'h1);
		wr(`GW_OFF_SLAVE, 32'hf7);
		rd(`GW_OFF_SLAVE, 32'hf7);
		rd(8'hfc, 32'h0);
		fire(1'b0, 8'h02, 8'hfe);
		chk("view", o_diag_view, 48'h0);
		wr(`GW_OFF_CFG, 32'h10e2);
		rd(`GW_OFF_CFG, 32'h10a2);
		fire(1'b0, 8'h02, 8'hfe);
		chk("view", o_diag_view, 48'h0105a00200fe);
		fire(1'b0, 8'h3c, 8'h00);
		chk("view", o_diag_view, 48'h0205a03c0000);
		fire(1'b1, 8'hfb, 8'h00);
		chk("view", o_diag_view, 48'h0305a0fb0000);
		repeat (8) fire(1'b0, 8'h3c, 8'h00);
		chk("view", o_diag_view, 48'h0a05a03c0000);
		i_pb_master_model.send(8'h00, 8'h01);
		i_pb_master_model.send(8'h01, 8'h01);
		#1 chk("view", o_diag_view, 48'h0);
		i_pb_master_model.send(8'h00, 8'h02);
		#1 chk("view", o_diag_view, 48'h0105a03f0000);
		wr(`GW_OFF_MOD_SEL, 32'h0);
		wr(`GW_OFF_MOD_A, 32'h1);
		wr(`GW_OFF_MOD_SEL, 32'h1);
		wr(`GW_OFF_MOD_A, 32'h2814);
		wr(`GW_OFF_COMMIT, 32'h0);
		rd(`GW_OFF_STATUS, 32'h11);
		rd(`GW_OFF_TOTALS, 32'h30008);
		wr(`GW_OFF_MOD_A, 32'h2014);
		wr(`GW_OFF_COMMIT, 32'h0);
		rd(`GW_OFF_STATUS, 32'h01);
		wr(`GW_OFF_MOD_A, 32'h1);
		wr(`GW_OFF_MOD_SEL, 32'h0);
		wr(`GW_OFF_MOD_A, 32'h2814);
		wr(`GW_OFF_COMMIT, 32'h0);
		#1 chk("view", o_diag_view, 48'h0205a03e0000);
		wr(`GW_OFF_CFG, 32'h14a2);
		@(posedge i_sys_clk);
		i_pb_exchange <= 1'b0;
		i_mb_link_ok <= 1'b0;
		@(posedge i_sys_clk);
		#1 chk("safe", {44'h0, o_safe}, 48'hf);
		@(posedge i_sys_clk);
		#1 chk("safe", {44'h0, o_safe}, 48'h1);
		end_sim();
	end
endmodule // tb_fieldbus_gateway_config_diag

// [verilog/fieldbus_gateway_config_diag.sv]
// gateway configuration, module map, safe state and diagnostic store
// assumes synchronous inputs, one 40 MHz clock and a register port
// with read data returned one cycle after the read strobe
`timescale 1ns/10ps
module fieldbus_gateway_config_diag #(
	parameter int MS_CYCLES = `GW_MS_CYCLES
) (
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_reset,
	input  wire logic [7:0]              i_addr,
	input  wire logic [31:0]             i_wdata,
	input  wire logic                    i_wr,
	input  wire logic                    i_rd,
	output logic [31:0]                  o_rdata,
	input  wire logic                    i_pb_exchange,
	input  wire logic                    i_mb_link_ok,
	input  gw_cfg_pkg::out_frame_s       i_out_frame,
	input  gw_cfg_pkg::event_s           i_module_err,
	input  gw_cfg_pkg::event_s           i_nv_fault,
	input  wire logic                    i_lost_input,
	input  wire logic                    i_query_sent,
	input  wire logic                    i_reply_seen,
	input  wire logic [4:0]              i_fmt_module,
	input  wire logic [31:0]             i_fmt_data,
	output gw_cfg_pkg::cfg_s             o_cfg,
	output logic                         o_baud_tick,
	output logic                         o_poll_tick,
	output logic                         o_reply_timeout,
	output gw_cfg_pkg::safe_s            o_safe,
	output logic                         o_out_refresh,
	output logic [7:0]                   o_out_select,
	output logic                         o_in_refresh,
	output logic                         o_setup_mode,
	output gw_cfg_pkg::diag_view_s       o_diag_view,
	output logic [31:0]                  o_fmt_data
);
	import gw_cfg_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		cfg_s                             cfg;
		mod_s [`GW_MAX_MODULES-1:0]       mods;
		logic [4:0]                       sel;
		diag_s [`GW_DIAG_DEPTH-1:0]       store;
		logic [3:0]                       count;
		logic [15:0]                      baud_cnt;
		logic                             baud_tick;
		logic [15:0]                      ms_cnt;
		logic                             ms_tick;
		logic [15:0]                      poll_cnt;
		logic                             poll_tick;
		logic                             wait_busy;
		logic [15:0]                      wait_cnt;
		logic                             timeout;
		logic                             pb_prev;
		logic                             mb_prev;
		safe_s                            safe;
		logic [7:0]                       prev_cmd;
		logic                             cmd_seen;
		logic                             refresh;
		logic [7:0]                       refresh_sel;
		logic                             in_refresh;
		logic                             setup_mode;
		logic                             layout_ok;
		logic [12:0]                      in_total;
		logic [12:0]                      out_total;
		logic [31:0]                      rdata;
		logic [31:0]                      fmt;
	} state_s;

	state_s state;
	state_s next_state;

	// ****************************************************************
	// functions
	// ****************************************************************
	function automatic logic [15:0] baud_div(input logic [2:0] sel);
		int rate;
		unique case (sel)
			3'h0: rate = `GW_RATE_0;
			3'h1: rate = `GW_RATE_1;
			3'h2: rate = `GW_RATE_2;
			3'h3: rate = `GW_RATE_3;
			3'h4: rate = `GW_RATE_4;
			3'h5: rate = `GW_RATE_5;
			default: rate = `GW_RATE_6;
		endcase
		baud_div = 16'(`GW_CLK_HZ / (`GW_OVERSAMPLE * rate));
	endfunction

	// input and output bytes a module takes in the cyclic areas
	function automatic logic [12:0] mod_bytes(input mod_s m,
			input logic want_in);
		logic [12:0] n;
		n = 13'h0;
		unique case (m.kind)
			MOD_SYSTEM:   n = want_in ? 13'h6 : 13'h3;
			MOD_BIT_IN:   n = want_in ? 13'(m.size) : 13'h0;
			MOD_BIT_OUT:  n = want_in ? 13'h0 : 13'(m.size);
			MOD_WORD_IN:  n = want_in ? 13'({m.size, 1'b0}) : 13'h0;
			MOD_WORD_OUT: n = want_in ? 13'h0 : 13'({m.size, 1'b0});
			default:      n = 13'h0;
		endcase
		mod_bytes = n;
	endfunction

	function automatic logic mod_ok(input mod_s m, input cfg_s c);
		logic ok;
		logic bitk;
		ok = 1'b1;
		bitk = (m.kind == MOD_BIT_IN) || (m.kind == MOD_BIT_OUT);
		if (bitk) begin
			// n bytes carry 8*(n-1)+1 .. 8*n bits
			if (m.size == 7'h0 || m.size > 7'h20)
				ok = 1'b0;
			else if (10'(m.bit_count) < {m.size - 7'h1, 3'h0} + 10'h1 ||
					10'(m.bit_count) > {m.size, 3'h0})
				ok = 1'b0;
		end
		if ((m.kind == MOD_WORD_IN || m.kind == MOD_WORD_OUT) &&
				(m.size == 7'h0 || m.size > 7'h40))
			ok = 1'b0;
		if (m.kind != MOD_NONE && m.kind != MOD_SYSTEM) begin
			if (m.target > `GW_MAX_ADDR)
				ok = 1'b0;
			if (c.frame == FRAME_TCP && (m.tcp_link_select == 4'h0 ||
					m.tcp_link_select > c.tcp_link_count))
				ok = 1'b0;
		end
		mod_ok = ok;
	endfunction

	// order a double word as the slave side expects
	function automatic logic [31:0] order_dword(input logic [31:0] d,
			input logic big, input logic swap);
		logic [31:0] w;
		w = swap ? {d[15:0], d[31:16]} : d;
		order_dword = big ? w : {w[23:16], w[31:24], w[7:0], w[15:8]};
	endfunction

	function automatic logic cause_ok(input logic [7:0] c);
		cause_ok = (c >= 8'h01 && c <= 8'h0b) || c == 8'hfd ||
			c == 8'hfe || c == 8'hf8 || c == 8'hf7;
	endfunction

	// ****************************************************************
	// layout check over the module table
	// ****************************************************************
	logic        sys_seen;
	logic        sys_first;
	logic        mods_ok;
	logic [12:0] sum_in;
	logic [12:0] sum_out;
	logic [5:0]  used;

	always_comb begin
		sys_seen = 1'b0;
		mods_ok = 1'b1;
		sum_in = 13'h0;
		sum_out = 13'h0;
		used = 6'h0;
		sys_first = state.mods[0].kind == MOD_SYSTEM;
		for (int i = 0; i < `GW_MAX_MODULES; i++) begin
			if (state.mods[i].kind == MOD_SYSTEM)
				sys_seen = 1'b1;
			if (state.mods[i].kind != MOD_NONE)
				used = used + 6'h1;
			mods_ok = mods_ok & mod_ok(state.mods[i], state.cfg);
			sum_in = sum_in + mod_bytes(state.mods[i], 1'b1);
			sum_out = sum_out + mod_bytes(state.mods[i], 1'b0);
		end
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	logic   commit;
	logic   clr;
	logic   cmd_changed;
	event_s push;
	logic [3:0] base;
	mod_s   cur;

	always_comb begin
		next_state = state;
		cur = state.mods[state.sel];
		commit = i_wr && i_addr == `GW_OFF_COMMIT;
		clr = i_out_frame.valid && i_out_frame.ctrl[0];
		cmd_changed = i_out_frame.valid &&
			(!state.cmd_seen || i_out_frame.cmd != state.prev_cmd);

		// register writes
		if (i_wr) begin
			unique case (i_addr)
				`GW_OFF_CFG: begin
					next_state.cfg.baud_sel = i_wdata[`GW_F_BAUD +: 3];
					next_state.cfg.parity =
						parity_e'(i_wdata[`GW_F_PARITY +: 2]);
					next_state.cfg.data8 = i_wdata[`GW_F_DATA8];
					next_state.cfg.stop2 = i_wdata[`GW_F_STOP2] &
						~i_wdata[`GW_F_DATA8];
					next_state.cfg.master = i_wdata[`GW_F_MASTER];
					next_state.cfg.frame =
						frame_e'(i_wdata[`GW_F_FRAME +: 2]);
					next_state.cfg.safe_switch = i_wdata[`GW_F_SAFE];
					next_state.cfg.big_endian = i_wdata[`GW_F_BIGEND];
					next_state.cfg.auto_out = i_wdata[`GW_F_AUTO];
				end
				`GW_OFF_SLAVE:
					if (i_wdata[7:0] != 8'h00 &&
							i_wdata[7:0] <= `GW_MAX_ADDR)
						next_state.cfg.slave_addr = i_wdata[7:0];
				`GW_OFF_POLL:
					if (i_wdata[15:0] != 16'h0)
						next_state.cfg.poll_ms = i_wdata[15:0];
				`GW_OFF_TIMEOUT:
					if (i_wdata[15:0] != 16'h0)
						next_state.cfg.timeout_ms = i_wdata[15:0];
				`GW_OFF_TCP:
					if (i_wdata[3:0] != 4'h0 &&
							i_wdata[3:0] <= `GW_MAX_LINKS)
						next_state.cfg.tcp_link_count = i_wdata[3:0];
				`GW_OFF_MOD_SEL: next_state.sel = i_wdata[4:0];
				`GW_OFF_MOD_A: begin
					next_state.mods[state.sel].kind =
						mod_kind_e'(i_wdata[2:0]);
					next_state.mods[state.sel].size = i_wdata[9:3];
					next_state.mods[state.sel].bit_count = i_wdata[18:10];
					next_state.mods[state.sel].access =
						access_e'(i_wdata[21:19]);
					next_state.mods[state.sel].word_swap = i_wdata[22];
					next_state.mods[state.sel].tcp_link_select =
						i_wdata[26:23];
				end
				`GW_OFF_MOD_B: begin
					next_state.mods[state.sel].target = i_wdata[7:0];
					next_state.mods[state.sel].start = i_wdata[23:8];
				end
				default: ;
			endcase
		end

		// layout is judged on commit
		if (commit) begin
			next_state.in_total = sum_in;
			next_state.out_total = sum_out;
			next_state.layout_ok = mods_ok && sys_first &&
				used <= 6'(`GW_MAX_MODULES) &&
				sum_in <= 13'(`GW_MAX_IO) &&
				sum_out <= 13'(`GW_MAX_IO);
		end

		// baud divider and millisecond base
		next_state.baud_tick = 1'b0;
		if (state.baud_cnt >= baud_div(state.cfg.baud_sel) - 16'h1) begin
			next_state.baud_cnt = 16'h0;
			next_state.baud_tick = 1'b1;
		end else
			next_state.baud_cnt = state.baud_cnt + 16'h1;
		next_state.ms_tick = 1'b0;
		if (state.ms_cnt >= 16'(MS_CYCLES - 1)) begin
			next_state.ms_cnt = 16'h0;
			next_state.ms_tick = 1'b1;
		end else
			next_state.ms_cnt = state.ms_cnt + 16'h1;

		// polling, master role only, counter cleared in setup mode
		next_state.poll_tick = 1'b0;
		if (!state.cfg.master || state.setup_mode)
			next_state.poll_cnt = 16'h0;
		else if (state.ms_tick) begin
			if (state.poll_cnt >= state.cfg.poll_ms - 16'h1) begin
				next_state.poll_cnt = 16'h0;
				next_state.poll_tick = 1'b1;
			end else
				next_state.poll_cnt = state.poll_cnt + 16'h1;
		end

		// reply timeout; a reply in the expiry cycle still counts
		next_state.timeout = 1'b0;
		if (i_query_sent && state.cfg.master) begin
			next_state.wait_busy = 1'b1;
			next_state.wait_cnt = 16'h0;
		end else if (i_reply_seen)
			next_state.wait_busy = 1'b0;
		else if (state.wait_busy && state.ms_tick) begin
			if (state.wait_cnt >= state.cfg.timeout_ms - 16'h1) begin
				next_state.wait_busy = 1'b0;
				next_state.timeout = 1'b1;
			end else
				next_state.wait_cnt = state.wait_cnt + 16'h1;
		end

		// safe state on link loss
		next_state.pb_prev = i_pb_exchange;
		next_state.mb_prev = i_mb_link_ok;
		next_state.safe.load_out = 1'b0;
		next_state.safe.send_slaves = 1'b0;
		next_state.safe.load_in = 1'b0;
		if (state.pb_prev && !i_pb_exchange && state.cfg.safe_switch) begin
			next_state.safe.load_out = 1'b1;
			next_state.safe.send_slaves = state.cfg.master;
		end
		if (state.mb_prev && !i_mb_link_ok && state.cfg.safe_switch &&
				state.cfg.master)
			next_state.safe.load_in = 1'b1;
		// master role only keeps last received values on modbus loss
		next_state.safe.hold = state.cfg.safe_switch &&
			(!i_pb_exchange || (state.cfg.master && !i_mb_link_ok));

		// cyclic output frame: command, control and select bytes
		next_state.refresh = 1'b0;
		next_state.in_refresh = i_out_frame.valid;
		if (i_out_frame.valid) begin
			next_state.setup_mode = i_out_frame.ctrl[1];
			next_state.cmd_seen = 1'b1;
			next_state.prev_cmd = i_out_frame.cmd;
			if (state.cfg.auto_out) begin
				next_state.refresh = 1'b1;
				next_state.refresh_sel = 8'h00;
			end else if (cmd_changed) begin
				next_state.refresh = 1'b1;
				next_state.refresh_sel = i_out_frame.select;
			end
		end

		// one diagnostic taken per cycle, by priority
		push = '0;
		if (commit && !sys_seen)
			push = '{1'b1, `GW_DG_NO_SYS, 8'h00};
		else if (commit && !sys_first)
			push = '{1'b1, `GW_DG_SYS_POS, 8'h00};
		else if (cmd_changed && state.cmd_seen &&
				i_out_frame.cmd != state.prev_cmd + 8'h01)
			push = '{1'b1, `GW_DG_LOST_OUT, 8'h00};
		else if (i_nv_fault.valid)
			push = '{1'b1, i_nv_fault.msg, 8'h00};
		else if (i_lost_input)
			push = '{1'b1, `GW_DG_LOST_IN, 8'h00};
		else if (i_module_err.valid && state.cfg.master &&
				cause_ok(i_module_err.cause))
			push = i_module_err;

		// clear first so a same-cycle event survives the clear
		base = clr ? 4'h0 : state.count;
		next_state.count = base;
		if (push.valid && base < 4'(`GW_DIAG_DEPTH)) begin
			next_state.store[base] = '{push.msg, push.cause};
			next_state.count = base + 4'h1;
		end

		// word formatting for the selected module
		next_state.fmt = order_dword(i_fmt_data, state.cfg.big_endian,
			state.mods[i_fmt_module].word_swap &&
			(state.mods[i_fmt_module].kind == MOD_WORD_IN ||
			state.mods[i_fmt_module].kind == MOD_WORD_OUT));

		// read data, stands one cycle after the strobe
		next_state.rdata = 32'h0;
		if (i_rd) begin
			unique case (i_addr)
				`GW_OFF_CFG: next_state.rdata = 32'({state.cfg.auto_out,
					state.cfg.big_endian, state.cfg.safe_switch,
					state.cfg.frame, state.cfg.master, state.cfg.stop2,
					state.cfg.data8, state.cfg.parity,
					state.cfg.baud_sel});
				`GW_OFF_SLAVE:   next_state.rdata = 32'(state.cfg.slave_addr);
				`GW_OFF_POLL:    next_state.rdata = 32'(state.cfg.poll_ms);
				`GW_OFF_TIMEOUT: next_state.rdata =
					32'(state.cfg.timeout_ms);
				`GW_OFF_TCP:     next_state.rdata =
					32'(state.cfg.tcp_link_count);
				`GW_OFF_MOD_SEL: next_state.rdata = 32'(state.sel);
				`GW_OFF_MOD_A:   next_state.rdata = 32'({cur.tcp_link_select,
					cur.word_swap, cur.access, cur.bit_count, cur.size,
					cur.kind});
				`GW_OFF_MOD_B:   next_state.rdata =
					32'({cur.start, cur.target});
				`GW_OFF_STATUS:  next_state.rdata = 32'({state.safe.hold,
					state.setup_mode, state.wait_busy, state.layout_ok,
					state.count});
				`GW_OFF_DIAG_LO: next_state.rdata = {o_diag_view.b3,
					o_diag_view.b2, o_diag_view.b1, o_diag_view.b0};
				`GW_OFF_DIAG_HI: next_state.rdata =
					32'({o_diag_view.b5, o_diag_view.b4});
				`GW_OFF_TOTALS:  next_state.rdata =
					32'({3'h0, state.out_total, 3'h0, state.in_total});
				default: next_state.rdata = 32'h0;
			endcase
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			state <= '0;
			state.cfg.baud_sel <= `GW_RST_BAUD;
			state.cfg.data8 <= 1'b1;
			state.cfg.slave_addr <= `GW_RST_SLAVE;
			state.cfg.poll_ms <= `GW_RST_POLL;
			state.cfg.timeout_ms <= `GW_RST_TIMEOUT;
			state.cfg.tcp_link_count <= `GW_RST_TCP;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	logic [3:0] last;
	assign last = state.count - 4'h1;

	always_comb begin
		o_diag_view = '0;
		o_diag_view.b0 = 8'(state.count);
		if (state.count != 4'h0) begin
			o_diag_view.b1 = `GW_DG_BYTE1;
			o_diag_view.b2 = `GW_DG_BYTE2;
			o_diag_view.b3 = state.store[last].msg;
			o_diag_view.b5 = state.store[last].cause;
		end
	end

	assign o_rdata = state.rdata;
	assign o_cfg = state.cfg;
	assign o_baud_tick = state.baud_tick;
	assign o_poll_tick = state.poll_tick;
	assign o_reply_timeout = state.timeout;
	assign o_safe = state.safe;
	assign o_out_refresh = state.refresh;
	assign o_out_select = state.refresh_sel;
	assign o_in_refresh = state.in_refresh;
	assign o_setup_mode = state.setup_mode;
	assign o_fmt_data = state.fmt;

endmodule // fieldbus_gateway_config_diag

// [verilog/gw_cfg_map.svh]
// constants for the gateway configuration and diagnostic block
// assumes one 40 MHz system clock and a plain register port
`ifndef GW_CFG_MAP_SVH
`define GW_CFG_MAP_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define GW_CLK_HZ        40000000
`define GW_TICK_MS       1
`define GW_MS_CYCLES     (`GW_CLK_HZ / 1000 * `GW_TICK_MS)
`define GW_OVERSAMPLE    16
`define GW_RATE_0        2400
`define GW_RATE_1        4800
`define GW_RATE_2        9600
`define GW_RATE_3        19200
`define GW_RATE_4        38400
`define GW_RATE_5        57600
`define GW_RATE_6        115200

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define GW_OFF_CFG       8'h00
`define GW_OFF_SLAVE     8'h04
`define GW_OFF_POLL      8'h08
`define GW_OFF_TIMEOUT   8'h0c
`define GW_OFF_TCP       8'h10
`define GW_OFF_MOD_SEL   8'h14
`define GW_OFF_MOD_A     8'h18
`define GW_OFF_MOD_B     8'h1c
`define GW_OFF_COMMIT    8'h20
`define GW_OFF_STATUS    8'h24
`define GW_OFF_DIAG_LO   8'h28
`define GW_OFF_DIAG_HI   8'h2c
`define GW_OFF_TOTALS    8'h30

// ****************************************************************
// field positions of the config word
// ****************************************************************
`define GW_F_BAUD        0
`define GW_F_PARITY      3
`define GW_F_DATA8       5
`define GW_F_STOP2       6
`define GW_F_MASTER      7
`define GW_F_FRAME       8
`define GW_F_SAFE        10
`define GW_F_BIGEND      11
`define GW_F_AUTO        12

// ****************************************************************
// reset values
// ****************************************************************
`define GW_RST_BAUD      3'h2
`define GW_RST_SLAVE     8'h01
`define GW_RST_POLL      16'h0064
`define GW_RST_TIMEOUT   16'h0064
`define GW_RST_TCP       4'h1

// ****************************************************************
// limits and diagnostic codes
// ****************************************************************
`define GW_MAX_MODULES   32
`define GW_MAX_IO        240
`define GW_DIAG_DEPTH    10
`define GW_MAX_ADDR      8'hf7
`define GW_MAX_LINKS     4'h8
`define GW_DG_NO_SYS     8'h3d
`define GW_DG_SYS_POS    8'h3e
`define GW_DG_LOST_IN    8'h3c
`define GW_DG_LOST_OUT   8'h3f
`define GW_DG_BYTE1      8'h05
`define GW_DG_BYTE2      8'ha0

`endif

// [verilog/gw_cfg_pkg.sv]
// types shared by the gateway configuration and diagnostic block
// assumes gw_cfg_map.svh is on the include path
`include "gw_cfg_map.svh"
package gw_cfg_pkg;

	typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_e;
	typedef enum logic [1:0] {FRAME_RTU, FRAME_ASCII, FRAME_TCP} frame_e;
	typedef enum logic [2:0] {MOD_NONE, MOD_SYSTEM, MOD_BIT_OUT,
		MOD_WORD_OUT, MOD_BIT_IN, MOD_WORD_IN} mod_kind_e;
	typedef enum logic [2:0] {WRITE_BIT_OUTPUTS, WRITE_WORD_OUTPUTS,
		READ_BIT_INPUTS, READ_BIT_OUTPUTS, READ_WORD_INPUTS,
		READ_WORD_OUTPUTS} access_e;

	typedef struct packed {
		logic [2:0]  baud_sel;
		parity_e     parity;
		logic        data8;
		logic        stop2;
		logic        master;
		frame_e      frame;
		logic        safe_switch;
		logic        big_endian;
		logic        auto_out;
		logic [7:0]  slave_addr;
		logic [15:0] poll_ms;
		logic [15:0] timeout_ms;
		logic [3:0]  tcp_link_count;
	} cfg_s;

	typedef struct packed {
		mod_kind_e   kind;
		logic [6:0]  size;
		logic [8:0]  bit_count;
		access_e     access;
		logic        word_swap;
		logic [3:0]  tcp_link_select;
		logic [7:0]  target;
		logic [15:0] start;
	} mod_s;

	typedef struct packed {
		logic [7:0] msg;
		logic [7:0] cause;
	} diag_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] cmd;
		logic [7:0] ctrl;
		logic [7:0] select;
	} out_frame_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] msg;
		logic [7:0] cause;
	} event_s;

	typedef struct packed {
		logic load_out;
		logic send_slaves;
		logic load_in;
		logic hold;
	} safe_s;

	typedef struct packed {
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] b3;
		logic [7:0] b4;
		logic [7:0] b5;
	} diag_view_s;

endpackage
